// *** design/fwd_map.svh ***
`ifndef FWD_MAP_SVH
`define FWD_MAP_SVH

// Register byte offsets
`define FWD_OFS_KEY 5'h00
`define FWD_OFS_DIV 5'h04
`define FWD_OFS_RELOAD 5'h08
`define FWD_OFS_STATUS 5'h0c
`define FWD_OFS_IRQ_STAT 5'h10
`define FWD_OFS_IRQ_CLR 5'h14
`define FWD_OFS_IRQ_EN 5'h18
`define FWD_OFS_COUNT 5'h1c

// Key codes, compared on the low half-word
`define FWD_KEY_START 16'hcccc
`define FWD_KEY_REFRESH 16'haaaa
`define FWD_KEY_UNLOCK 16'h5555

// Field positions and widths
`define FWD_DIV_W 3
`define FWD_CNT_W 12
`define FWD_BUSY_DIV_BIT 0
`define FWD_BUSY_RLD_BIT 1
`define FWD_IRQ_W 3

// Reset values and highest prescaler select code
`define FWD_DIV_RST 3'h0
`define FWD_RELOAD_RST 12'hfff
`define FWD_COUNT_START 12'hfff
`define FWD_DIV_MAX_SEL 3'h6

`endif

// *** design/fwd_pkg.sv ***
package fwd_pkg;

  // Run state of the down-counter, Gray coded along idle, run, expired
  typedef enum logic [1:0] {
    FWD_IDLE = 2'b00,
    FWD_RUN = 2'b01,
    FWD_EXPIRED = 2'b11
  } fwd_state_type;

  // Interrupt events, one bit each
  typedef struct packed {
    logic locked_write;
    logic refreshed;
    logic timeout;
  } fwd_irq_type;

  // Key commands waiting for the next oscillator tick
  typedef struct packed {
    logic start;
    logic refresh;
  } fwd_keycmd_type;

endpackage

// *** design/fwd_osc_tick.sv ***
`timescale 1ns/10ps

module fwd_osc_tick (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Oscillator pin and its rising-edge pulse
  input wire logic low_speed_osc,
  output logic osc_tick
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // Two-flop synchroniser, then edge detect on the second stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      osc_tick <= 1'b0;
    end else begin
      sync1_q <= low_speed_osc;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      osc_tick <= sync2_q & ~prev_q;
    end
  end

endmodule

// *** design/fwd_prescale.sv ***
`timescale 1ns/10ps
`include "fwd_map.svh"

module fwd_prescale (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Oscillator ticks in, divided ticks out
  input wire logic osc_tick,
  input wire logic [`FWD_DIV_W-1:0] sel,
  output logic div_tick
);

  logic [7:0] cnt_q;
  logic [2:0] sel_eff;
  logic [7:0] term;

  // Codes 6 and 7 both give divide by 256
  assign sel_eff = (sel > `FWD_DIV_MAX_SEL) ? `FWD_DIV_MAX_SEL : sel;
  assign term = 8'((9'h004 << sel_eff) - 9'h001);

  // Divide oscillator ticks by 4 << sel_eff
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      div_tick <= 1'b0;
    end else begin
      div_tick <= 1'b0;
      if (osc_tick) begin
        if (cnt_q >= term) begin
          cnt_q <= 8'h00;
          div_tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule

// *** design/fwd_watchdog.sv ***
//Contract
// - Start key begins count down from 0xfff.
// - Counter reaching zero asserts the system reset output.
// - Refresh key loads the reload value into the counter.
// - No register write stops a running counter; only reset does.
// - Hardware-start option starts the counter right after reset.
// - Unlock key opens prescaler and reload registers for writes.
// - Any other key value locks them again.
// - Prescaler codes 0 to 6 divide by 4 to 256; 7 gives 256.
// - Busy flags show updates not yet taken by the counter side.
// - Twelve-bit reload; counter restarts from it on each refresh.
// - Debug halt freezes the counter when the freeze bit is set.
// - Counter is paced only by the low-speed oscillator.
// - Status bit 0 prescaler busy, bit 1 reload busy, read-only.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "fwd_map.svh"

module fwd_watchdog (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [4:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator pin, option strap, debug controls
  input wire logic low_speed_osc,
  input wire logic hw_start_opt,
  input wire logic dbg_halted,
  input wire logic debug_freeze_bit,
  // Reset request and interrupt
  output logic sys_reset_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  fwd_pkg::fwd_state_type state_q;
  fwd_pkg::fwd_keycmd_type cmd_q;
  fwd_pkg::fwd_irq_type irq_stat_q;
  fwd_pkg::fwd_irq_type irq_en_q;
  fwd_pkg::fwd_irq_type ev;
  logic [`FWD_CNT_W-1:0] count_q;
  logic [`FWD_CNT_W-1:0] reload_q;
  logic [`FWD_CNT_W-1:0] reload_act_q;
  logic [`FWD_DIV_W-1:0] div_q;
  logic [`FWD_DIV_W-1:0] div_act_q;
  logic busy_div_q;
  logic busy_rld_q;
  logic unlock_q;
  logic strap_done_q;
  logic osc_tick;
  logic div_tick;
  logic count_en;
  logic setup;
  logic commit;
  logic wr;
  logic key_wr;
  logic div_wr;
  logic rld_wr;
  logic [15:0] key;
  logic [31:0] rdata;
  logic known;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator pacing

  // Oscillator pin is synchronised and turned into one-cycle ticks
  fwd_osc_tick u_tick (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .low_speed_osc(low_speed_osc),
    .osc_tick(osc_tick)
  );

  // Divided tick paces the counter
  fwd_prescale u_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .osc_tick(osc_tick),
    .sel(div_act_q),
    .div_tick(div_tick)
  );

  // Freeze while halted in debug if the freeze bit asks for it
  assign count_en = div_tick & ~(dbg_halted & debug_freeze_bit);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Access phase with ready sampled high is the commit edge
  assign setup = psel & penable & ~pready;
  assign commit = psel & penable & pready;
  assign wr = commit & pwrite & ~pslverr;
  assign key_wr = wr & (paddr == `FWD_OFS_KEY);
  assign div_wr = wr & (paddr == `FWD_OFS_DIV);
  assign rld_wr = wr & (paddr == `FWD_OFS_RELOAD);
  assign key = pwdata[15:0];

  // Read mux and address check
  always_comb begin
    rdata = 32'h0000_0000;
    known = 1'b1;
    case (paddr)
      `FWD_OFS_KEY: rdata = 32'h0000_0000;
      `FWD_OFS_DIV: rdata[`FWD_DIV_W-1:0] = div_q;
      `FWD_OFS_RELOAD: rdata[`FWD_CNT_W-1:0] = reload_q;
      `FWD_OFS_STATUS: begin
        rdata[`FWD_BUSY_DIV_BIT] = busy_div_q;
        rdata[`FWD_BUSY_RLD_BIT] = busy_rld_q;
      end
      `FWD_OFS_IRQ_STAT: rdata[`FWD_IRQ_W-1:0] = irq_stat_q;
      `FWD_OFS_IRQ_CLR: rdata = 32'h0000_0000;
      `FWD_OFS_IRQ_EN: rdata[`FWD_IRQ_W-1:0] = irq_en_q;
      `FWD_OFS_COUNT: rdata[`FWD_CNT_W-1:0] = count_q;
      default: known = 1'b0;
    endcase
  end

  // Ready one cycle into the access phase; error on unmapped offsets
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~known;
      if (setup & ~pwrite) begin
        prdata <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write protection

  // Unlock key opens access, any other key value closes it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unlock_q <= 1'b0;
    end else if (key_wr) begin
      unlock_q <= (key == `FWD_KEY_UNLOCK);
    end
  end

  // Prescaler select, written only while unlocked
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= `FWD_DIV_RST;
    end else if (div_wr & unlock_q) begin
      div_q <= pwdata[`FWD_DIV_W-1:0];
    end
  end

  // Reload value, written only while unlocked
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reload_q <= `FWD_RELOAD_RST;
    end else if (rld_wr & unlock_q) begin
      reload_q <= pwdata[`FWD_CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer into the oscillator-paced side

  // Busy flags: set by an accepted write, cleared at the next tick;
  // a write in the tick cycle keeps the flag set
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_div_q <= 1'b0;
      busy_rld_q <= 1'b0;
    end else begin
      if (div_wr & unlock_q) begin
        busy_div_q <= 1'b1;
      end else if (osc_tick) begin
        busy_div_q <= 1'b0;
      end
      if (rld_wr & unlock_q) begin
        busy_rld_q <= 1'b1;
      end else if (osc_tick) begin
        busy_rld_q <= 1'b0;
      end
    end
  end

  // Working copies taken on an oscillator tick
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_act_q <= `FWD_DIV_RST;
      reload_act_q <= `FWD_RELOAD_RST;
    end else if (osc_tick) begin
      div_act_q <= div_q;
      reload_act_q <= reload_q;
    end
  end

  // Key commands wait here until the next oscillator tick
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= '0;
    end else begin
      if (osc_tick) begin
        cmd_q <= '0;
      end
      if (key_wr & (key == `FWD_KEY_START)) begin
        cmd_q.start <= 1'b1;
      end
      if (key_wr & (key == `FWD_KEY_REFRESH)) begin
        cmd_q.refresh <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run state and down-counter

  // Strap is caught once, on the first clock after reset release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
    end
  end

  // Idle until started; once running only reset returns to idle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fwd_pkg::FWD_IDLE;
    end else begin
      case (state_q)
        fwd_pkg::FWD_IDLE: begin
          if (!strap_done_q & hw_start_opt) begin
            state_q <= fwd_pkg::FWD_RUN;
          end else if (osc_tick & cmd_q.start) begin
            state_q <= fwd_pkg::FWD_RUN;
          end
        end
        fwd_pkg::FWD_RUN: begin
          if (count_q == '0) begin
            state_q <= fwd_pkg::FWD_EXPIRED;
          end
        end
        fwd_pkg::FWD_EXPIRED: state_q <= fwd_pkg::FWD_EXPIRED;
        default: state_q <= fwd_pkg::FWD_IDLE;
      endcase
    end
  end

  // Down-counter: full count on start, reload on refresh, else decrement
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= `FWD_COUNT_START;
    end else if (state_q == fwd_pkg::FWD_IDLE) begin
      count_q <= `FWD_COUNT_START;
    end else if (state_q == fwd_pkg::FWD_RUN) begin
      if (osc_tick & cmd_q.refresh) begin
        count_q <= reload_q;
      end else if (count_en & (count_q != '0)) begin
        count_q <= count_q - 12'h001;
      end
    end
  end

  // Reset request held once the count reaches zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_req <= 1'b0;
    end else if (state_q != fwd_pkg::FWD_IDLE && count_q == '0) begin
      sys_reset_req <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Events: timeout, refresh taken, write refused by the lock
  assign ev.timeout = (state_q == fwd_pkg::FWD_RUN) & (count_q == '0);
  assign ev.refreshed = (state_q == fwd_pkg::FWD_RUN) & osc_tick
                        & cmd_q.refresh;
  assign ev.locked_write = (div_wr | rld_wr) & ~unlock_q;

  // Sticky status; an event in the clear cycle wins over the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= '0;
    end else if (wr & (paddr == `FWD_OFS_IRQ_CLR)) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[`FWD_IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  // Enable register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_q <= '0;
    end else if (wr & (paddr == `FWD_OFS_IRQ_EN)) begin
      irq_en_q <= pwdata[`FWD_IRQ_W-1:0];
    end
  end

  // Level interrupt from the stored status and enables
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

endmodule

// *** testbench/fwd_watchdog_chk.sv ***
`timescale 1ns/10ps

module fwd_watchdog_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [4:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reset request
  input wire logic sys_reset_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////
  // Setup then first access cycle
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence

  // Completed read of one offset
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  AST_READY_LAT: assert property (s_access |=> pready)
    else $error("pready not one wait state");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_BUS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_SETUP_QUIET: assert property (psel && !penable |-> !pready)
    else $error("pready in setup cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_KEY_ZERO: assert property (s_rd(5'h00) |-> prdata == 32'h0)
    else $error("key register read not zero");
  AST_DIV_WIDTH: assert property (s_rd(5'h04) |-> ~|prdata[31:3])
    else $error("prescaler read has high bits");
  AST_RLD_WIDTH: assert property (s_rd(5'h08) |-> ~|prdata[31:12])
    else $error("reload read has high bits");
  AST_STAT_BITS: assert property (s_rd(5'h0c) |-> ~|prdata[31:2])
    else $error("status read has high bits");
  AST_RESET_HOLD: assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped");
endmodule

bind fwd_watchdog fwd_watchdog_chk fwd_watchdog_chk_i (.clk_sys(clk_sys),
  .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sys_reset_req(sys_reset_req));

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`include "fwd_map.svh"

module tb_top;
  logic clk_sys, rst_b, psel, penable, pwrite, osc, hw, halt, frz;
  logic pready, pslverr, sys_reset_req, irq, err_v;
  logic [4:0] paddr, oc;
  logic [31:0] pwdata, prdata, rd_v;
  int n_errors, checks;

  fwd_watchdog fwd_watchdog_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_osc(osc), .hw_start_opt(hw), .dbg_halted(halt),
    .debug_freeze_bit(frz), .sys_reset_req(sys_reset_req), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  // System clock, 5 ns
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Oscillator pin, one period per 40 clocks
  always @(posedge clk_sys) begin
    oc <= (oc == 5'd19) ? 5'd0 : oc + 5'd1;
    if (oc == 5'd19)
      osc <= ~osc;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // One APB transfer, held until pready; only the hang guard ends a wait
  task apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [4:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e, m);
  endtask

  task do_reset(input logic h);
    rst_b <= 1'b0;
    hw <= h;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask

  task wait_req(output int c);
    c = 0;
    while (sys_reset_req !== 1'b1 && c < 5000) begin
      @(posedge clk_sys);
      c++;
    end
  endtask

  // Poll busy flags until both clear
  task wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `FWD_OFS_STATUS, 32'h0);
      n++;
    end while (rd_v[1:0] !== 2'b00 && n < 20);
    chk(rd_v, 0, "busy stuck");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`FWD_OFS_KEY, 0, "key read");
    rd(`FWD_OFS_DIV, 0, "prescaler reset");
    rd(`FWD_OFS_RELOAD, 32'hfff, "reload reset");
    rd(`FWD_OFS_STATUS, 0, "status reset");
    chk(err_v, 0, "mapped read error");
    // Unaligned offset is unmapped and must answer with an error
    rd(5'h02, 0, "unmapped read data");
    chk(err_v, 1, "unmapped error");
  endtask

  task t_lock;
    wr(`FWD_OFS_RELOAD, 32'h3);
    rd(`FWD_OFS_RELOAD, 32'hfff, "locked write taken");
    rd(`FWD_OFS_IRQ_STAT, 32'h4, "refused flag");
    wr(`FWD_OFS_IRQ_CLR, 32'h7);
    // Write just after a tick so busy is still visible
    @(posedge osc);
    repeat (6) @(posedge clk_sys);
    wr(`FWD_OFS_KEY, 32'h5555);
    wr(`FWD_OFS_DIV, 32'h7);
    wr(`FWD_OFS_RELOAD, 32'h3);
    rd(`FWD_OFS_STATUS, 32'h3, "busy flags");
    wait_idle;
    rd(`FWD_OFS_DIV, 32'h7, "prescaler write");
    rd(`FWD_OFS_RELOAD, 32'h3, "reload write");
    wr(`FWD_OFS_KEY, 32'haaaa);
    wr(`FWD_OFS_RELOAD, 32'h9);
    rd(`FWD_OFS_RELOAD, 32'h3, "relock");
    wr(`FWD_OFS_KEY, 32'h5555);
    wr(`FWD_OFS_DIV, 32'h0);
    wait_idle;
  endtask

  task t_run;
    int c, a;
    wr(`FWD_OFS_IRQ_EN, 32'h2);
    halt <= 1'b1;
    wr(`FWD_OFS_KEY, 32'hcccc);
    repeat (100) @(posedge clk_sys);
    apb(1'b0, `FWD_OFS_COUNT, 32'h0);
    chk(rd_v[11:4], 32'hff, "start count");
    a = rd_v[11:0];
    wr(`FWD_OFS_KEY, 32'h0);
    wr(`FWD_OFS_KEY, 32'hcccc);
    repeat (400) @(posedge clk_sys);
    apb(1'b0, `FWD_OFS_COUNT, 32'h0);
    chk(rd_v[11:0] < a, 1, "counter stopped");
    frz <= 1'b1;
    repeat (10) @(posedge clk_sys);
    apb(1'b0, `FWD_OFS_COUNT, 32'h0);
    a = rd_v[11:0];
    repeat (400) @(posedge clk_sys);
    rd(`FWD_OFS_COUNT, a, "freeze");
    frz <= 1'b0;
    halt <= 1'b0;
    wr(`FWD_OFS_KEY, 32'haaaa);
    repeat (50) @(posedge clk_sys);
    apb(1'b0, `FWD_OFS_COUNT, 32'h0);
    chk(rd_v[11:2], 0, "refresh load");
    chk(irq, 1, "irq raise");
    wr(`FWD_OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0, "irq mask");
    wr(`FWD_OFS_IRQ_EN, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1, "irq unmask");
    wr(`FWD_OFS_IRQ_CLR, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0, "irq clear");
    // Fresh refresh: 3 x 160 clocks, less the prescaler phase, plus sync
    wr(`FWD_OFS_KEY, 32'haaaa);
    wait_req(c);
    chk(c >= 324 && c <= 483, 1, "timeout span");
    apb(1'b0, `FWD_OFS_IRQ_STAT, 32'h0);
    chk(rd_v[0], 1, "timeout flag");
  endtask

  task t_hw;
    int c;
    do_reset(1'b1);
    wr(`FWD_OFS_KEY, 32'h5555);
    wr(`FWD_OFS_RELOAD, 32'h3);
    wr(`FWD_OFS_KEY, 32'haaaa);
    wait_req(c);
    chk(sys_reset_req, 1, "hardware start");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, osc, hw, halt, frz} = 8'h0;
    paddr = 5'h0;
    pwdata = 32'h0;
    oc = 5'h0;
    do_reset(1'b0);
    t_regs;
    t_lock;
    t_run;
    t_hw;
    results;
  end

  // Hang guard
  initial begin
    #400000;
    n_errors++;
    results;
  end
endmodule
